// *** design/multi_function_pin_control.v ***
/*
  multi-function pin control: user/interrupt/channel-busy pin, two indicator pins and the
  serial-device clock pin, with a classic wishbone register slave and a level interrupt.
  assumes pins arrive asynchronously; internal_cca and isa_irq_request are on clk.
*/
// Implementation choices: the placing of the registers and the Wishbone register port.
// What this block does
// [R01] user pin data bit reads the live user pin level in every configuration
// [R02] external busy enable forces the user pin to input over all other settings
// [R03] with external busy enabled, pin level feeds busy-change, busy and flag bits
// [R04] external busy source replaces internal clear-channel result in same bit positions
// [R05] busy-change and busy-flag bits each interrupt when active and unmasked
// [R06] controller interrupt depends only on busy enable and unmask, not direction bits
// [R07] isa strap, function 0, select 4h: drive irq totem for 2h, open-drain for 1h
// [R08] otherwise user pin output enable picks input or driving the user data bit
// [R09] traffic data bit reads the live traffic pin level always
// [R10] traffic pin: input, open-drain float/low, or totem high/low; reset open-drain float
// [R11] link pin works like traffic pin with its own bits and same reset
// [R12] serial clock data bit reads the live serial clock pin level always
// [R13] serial clock enable 0 is input; pulse mode 0 drives data; reset low output
// [R14] pulse mode: each serial control write emits one pulse, polarity from data bit
// [R15] each auto-pulse lasts one clock cycle then returns to idle level
// [R16] external busy pin passes two flip-flops before status or interrupt logic
`timescale 1ns/1ps
`include "pin_ctrl_defs.vh"

module multi_function_pin_control (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq,
  input wire isa_strap,
  input wire internal_cca,
  input wire isa_irq_request,
  input wire user_irq_busy_pin_i,
  output reg user_irq_busy_pin_o,
  output reg user_irq_busy_pin_oe,
  input wire traffic_indicator_pin_i,
  output reg traffic_indicator_pin_o,
  output reg traffic_indicator_pin_oe,
  input wire link_indicator_pin_i,
  output reg link_indicator_pin_o,
  output reg link_indicator_pin_oe,
  input wire serial_device_clock_pin_i,
  output reg serial_device_clock_pin_o,
  output reg serial_device_clock_pin_oe
);

  // two-stage synchronisers for every pin input
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  wire user_live;
  wire traffic_live;
  wire link_live;
  wire serial_live;
  wire isa_live;

  reg [1:0] function_reg;
  reg [3:0] enable_reg;
  reg [1:0] drive_reg;
  reg [1:0] indicator_reg;
  reg user_data;
  reg [1:0] serial_reg;
  reg [3:0] irq_select;
  reg [3:0] irq_type;
  reg [1:0] int_status;
  reg [1:0] int_enable;
  reg isa_mode;
  reg busy_prev;
  reg pulse;

  wire ext_busy_en;
  wire busy_level;
  wire busy_change;
  wire [1:0] int_set;
  wire [1:0] int_clr;
  wire [1:0] next_int_status;
  wire access;
  wire wr;
  wire [31:0] be_mask;
  wire [31:0] wdata;
  wire serial_write;

  reg [31:0] next_rdata;
  reg next_user_o;
  reg next_user_oe;
  reg next_serial_o;

  // open-drain or totem drive of an indicator pin
  function [1:0] indicator_drive;
    input en;
    input totem;
    input data;
    begin
      if (!en) begin
        indicator_drive = 2'h0;
      end else if (totem) begin
        indicator_drive = {1'b1, ~data};
      end else begin
        indicator_drive = {data, 1'b0};
      end
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {isa_strap, serial_device_clock_pin_i, link_indicator_pin_i,
                 traffic_indicator_pin_i, user_irq_busy_pin_i};
      sync_b <= sync_a; // [R16]
    end
  end

  assign user_live = sync_b[0];
  assign traffic_live = sync_b[1];
  assign link_live = sync_b[2];
  assign serial_live = sync_b[3];
  assign isa_live = sync_b[4];

  assign ext_busy_en = function_reg[`FN_EXT_BUSY];
  assign busy_level = ext_busy_en ? user_live : internal_cca; // [R03] [R04] [R16]
  assign busy_change = busy_level ^ busy_prev;
  assign int_set = {busy_level, busy_change}; // [R03] [R05]

  assign access = wb_cyc_i & wb_stb_i;
  assign wr = access & wb_we_i & wb_ack_o;
  assign be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i & be_mask;
  assign serial_write = wr & (wb_adr_i == `OFS_SERIAL) & wb_sel_i[0];
  assign int_clr = (wr & (wb_adr_i == `OFS_INT_CLEAR) & wb_sel_i[0]) ? wdata[1:0] : 2'h0;
  // set wins over a clear in the same cycle
  assign next_int_status = (int_status & ~int_clr) | int_set; // [R05]

  // register read mux
  always @* begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `OFS_FUNCTION: next_rdata[1:0] = function_reg;
      `OFS_ENABLE: next_rdata[3:0] = enable_reg;
      `OFS_DRIVE: next_rdata[1:0] = drive_reg;
      `OFS_INDICATOR: next_rdata[1:0] = {link_live, traffic_live}; // [R09] [R11]
      `OFS_USER_DATA: next_rdata[0] = user_live; // [R01]
      `OFS_SERIAL: next_rdata[1:0] = {serial_reg[`SC_PULSE], serial_live}; // [R12]
      `OFS_IRQ_SELECT: next_rdata[3:0] = irq_select;
      `OFS_IRQ_TYPE: next_rdata[3:0] = irq_type;
      `OFS_CHANNEL: next_rdata[1:0] = {busy_level, busy_level}; // [R03] [R04]
      `OFS_INT_STATUS: next_rdata[1:0] = int_status;
      `OFS_INT_ENABLE: next_rdata[1:0] = int_enable;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // bus answer one cycle after the request, dropped the cycle after
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access & ~wb_ack_o;
      wb_dat_o <= (access & ~wb_ack_o & ~wb_we_i) ? next_rdata : 32'h00000000;
    end
  end

  // control registers, written at the edge where ack is high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      function_reg <= `RST_FUNCTION;
      enable_reg <= `RST_ENABLE; // [R10] [R11] [R13]
      drive_reg <= `RST_DRIVE;
      indicator_reg <= `RST_INDICATOR;
      user_data <= 1'b0;
      serial_reg <= `RST_SERIAL;
      irq_select <= `RST_IRQ_SELECT;
      irq_type <= `RST_IRQ_TYPE;
      int_enable <= `RST_INT_ENABLE;
    end else if (wr & wb_sel_i[0]) begin
      case (wb_adr_i)
        `OFS_FUNCTION: function_reg <= wdata[1:0];
        `OFS_ENABLE: enable_reg <= wdata[3:0];
        `OFS_DRIVE: drive_reg <= wdata[1:0];
        `OFS_INDICATOR: indicator_reg <= wdata[1:0];
        `OFS_USER_DATA: user_data <= wdata[0];
        `OFS_SERIAL: serial_reg <= wdata[1:0];
        `OFS_IRQ_SELECT: irq_select <= wdata[3:0];
        `OFS_IRQ_TYPE: irq_type <= wdata[3:0];
        `OFS_INT_ENABLE: int_enable <= wdata[1:0];
        default: function_reg <= function_reg;
      endcase
    end
  end

  // strap sampled every cycle after reset release, sticky status, interrupt, pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      isa_mode <= 1'b0;
      busy_prev <= 1'b0;
      int_status <= 2'h0;
      irq <= 1'b0;
      pulse <= 1'b0;
    end else begin
      isa_mode <= isa_live;
      busy_prev <= busy_level;
      int_status <= next_int_status; // [R05]
      irq <= |(next_int_status & int_enable); // [R05] [R06]
      pulse <= serial_write & wdata[`SC_PULSE] & enable_reg[`EN_SERIAL]; // [R14] [R15]
    end
  end

  // user pin direction and data
  always @* begin
    next_user_o = 1'b0;
    next_user_oe = 1'b0;
    if (ext_busy_en) begin
      next_user_oe = 1'b0; // [R02]
    end else if (isa_mode & ~function_reg[`FN_USER_FUNC] & (irq_select == `IRQ_SELECT_USER)) begin
      if (irq_type == `IRQ_TYPE_TOTEM) begin
        next_user_o = isa_irq_request; // [R07]
        next_user_oe = 1'b1;
      end else if (irq_type == `IRQ_TYPE_OPEN) begin
        next_user_oe = ~isa_irq_request; // [R07]
      end
    end else begin
      next_user_oe = enable_reg[`EN_USER]; // [R08]
      next_user_o = user_data;
    end
  end

  // serial clock level: idle at data bit, inverted for one cycle on a pulse
  always @* begin
    next_serial_o = serial_reg[`SC_DATA]; // [R13]
    if (pulse) begin
      next_serial_o = ~serial_reg[`SC_DATA]; // [R14] [R15]
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      user_irq_busy_pin_o <= 1'b0;
      user_irq_busy_pin_oe <= 1'b0;
      traffic_indicator_pin_o <= 1'b0;
      traffic_indicator_pin_oe <= 1'b0;
      link_indicator_pin_o <= 1'b0;
      link_indicator_pin_oe <= 1'b0;
      serial_device_clock_pin_o <= 1'b0;
      serial_device_clock_pin_oe <= 1'b0;
    end else begin
      user_irq_busy_pin_o <= next_user_o;
      user_irq_busy_pin_oe <= next_user_oe;
      {traffic_indicator_pin_oe, traffic_indicator_pin_o} <= indicator_drive(
        enable_reg[`EN_TRAFFIC], drive_reg[`DR_TRAFFIC], indicator_reg[`IND_TRAFFIC]); // [R10]
      {link_indicator_pin_oe, link_indicator_pin_o} <= indicator_drive(
        enable_reg[`EN_LINK], drive_reg[`DR_LINK], indicator_reg[`IND_LINK]); // [R11]
      serial_device_clock_pin_o <= next_serial_o;
      serial_device_clock_pin_oe <= enable_reg[`EN_SERIAL]; // [R13]
    end
  end

endmodule // multi_function_pin_control

// *** design/pin_ctrl_defs.vh ***
/*
  register offsets, field positions and reset values of the multi-function pin block.
  assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
*/
`ifndef PIN_CTRL_DEFS_VH
`define PIN_CTRL_DEFS_VH

`define ADDR_W 6
`define OFS_FUNCTION 6'h00
`define OFS_ENABLE 6'h04
`define OFS_DRIVE 6'h08
`define OFS_INDICATOR 6'h0C
`define OFS_USER_DATA 6'h10
`define OFS_SERIAL 6'h14
`define OFS_IRQ_SELECT 6'h18
`define OFS_IRQ_TYPE 6'h1C
`define OFS_CHANNEL 6'h20
`define OFS_INT_STATUS 6'h24
`define OFS_INT_ENABLE 6'h28
`define OFS_INT_CLEAR 6'h2C

// function register
`define FN_USER_FUNC 0
`define FN_EXT_BUSY 1
// enable register
`define EN_USER 0
`define EN_TRAFFIC 1
`define EN_LINK 2
`define EN_SERIAL 3
// drive-type register
`define DR_TRAFFIC 0
`define DR_LINK 1
// indicator data register
`define IND_TRAFFIC 0
`define IND_LINK 1
// serial control register
`define SC_DATA 0
`define SC_PULSE 1
// channel register
`define CH_BUSY 0
`define CH_FLAG 1
// interrupt status, enable and clear
`define INT_BUSY_CHANGE 0
`define INT_BUSY_FLAG 1

`define RST_FUNCTION 2'h0
`define RST_ENABLE 4'hE
`define RST_DRIVE 2'h0
`define RST_INDICATOR 2'h0
`define RST_SERIAL 2'h0
`define RST_IRQ_SELECT 4'h0
`define RST_IRQ_TYPE 4'h0
`define RST_INT_ENABLE 2'h0

`define IRQ_SELECT_USER 4'h4
`define IRQ_TYPE_TOTEM 4'h2
`define IRQ_TYPE_OPEN 4'h1

`endif

// *** verif/pin_board.sv ***
/* board around the pins: pull-ups and an optional external driver per pin.
   assumes index 0 user, 1 traffic, 2 link, 3 serial clock. */
`timescale 1ns/1ps
module pin_board (
  input wire [3:0] oe,
  input wire [3:0] o,
  input wire [3:0] ext_en,
  input wire [3:0] ext_val,
  output wire [3:0] level
);
  // the board drives a pin only while the block leaves it as input
  assign level = (oe & o) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
endmodule // pin_board

// *** verif/pin_ctrl_asserts.sv ***
/* assertions on the pin control ports.
   assumes one clock and a master that holds each request until ack. */
`timescale 1ns/1ps
`include "pin_ctrl_defs.vh"
module pin_ctrl_asserts (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire irq,
  input wire user_irq_busy_pin_oe,
  input wire traffic_indicator_pin_o,
  input wire traffic_indicator_pin_oe,
  input wire link_indicator_pin_oe,
  input wire serial_device_clock_pin_o,
  input wire serial_device_clock_pin_oe
);
  reg run;
  reg [1:0] fn, dr, ind, sc, ie;
  reg [3:0] en;
  wire wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  wire wr_sc = wr && wb_adr_i == `OFS_SERIAL;
  // shadow copies of the control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run <= 1'b0;
      fn <= `RST_FUNCTION;
      en <= `RST_ENABLE;
      dr <= `RST_DRIVE;
      ind <= `RST_INDICATOR;
      sc <= `RST_SERIAL;
      ie <= `RST_INT_ENABLE;
    end else begin
      run <= 1'b1;
      if (wr && wb_adr_i == `OFS_FUNCTION) fn <= wb_dat_i[1:0];
      if (wr && wb_adr_i == `OFS_ENABLE) en <= wb_dat_i[3:0];
      if (wr && wb_adr_i == `OFS_DRIVE) dr <= wb_dat_i[1:0];
      if (wr && wb_adr_i == `OFS_INDICATOR) ind <= wb_dat_i[1:0];
      if (wr_sc) sc <= wb_dat_i[1:0];
      if (wr && wb_adr_i == `OFS_INT_ENABLE) ie <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !run);
  AST_EXT_INPUT: assert property (fn[1] |=> !user_irq_busy_pin_oe)
    else $error("user pin driven with external busy on");
  AST_TRAFFIC_OE: assert property (
    traffic_indicator_pin_oe == $past(en[1] && (dr[0] || ind[0])))
    else $error("traffic enable wrong");
  AST_TRAFFIC_O: assert property (
    traffic_indicator_pin_oe |-> traffic_indicator_pin_o == $past(dr[0] && !ind[0]))
    else $error("traffic level wrong");
  AST_LINK_OE: assert property (en[2] && dr[1] |=> link_indicator_pin_oe)
    else $error("link totem not driving");
  AST_SERIAL_OE: assert property (serial_device_clock_pin_oe == $past(en[3]))
    else $error("serial enable wrong");
  AST_SERIAL_LEVEL: assert property (
    en[3] && !sc[1] && $stable(sc) |=> serial_device_clock_pin_o == $past(sc[0]))
    else $error("serial static level wrong");
  AST_PULSE_FIRE: assert property (
    wr_sc && wb_dat_i[1] && en[3] |-> ##[2:4] serial_device_clock_pin_o != sc[0])
    else $error("serial pulse missing");
  AST_PULSE_ONE: assert property (
    en[3] && sc[1] && $stable(sc) && serial_device_clock_pin_o != sc[0]
    |=> serial_device_clock_pin_o == sc[0])
    else $error("serial pulse too long");
  AST_IRQ_MASK: assert property (ie == 2'h0 |=> !irq)
    else $error("irq while all masked");
  COV_PULSE: cover property (wr_sc && wb_dat_i[1]);
  COV_IRQ: cover property ($rose(irq));
  COV_EXT: cover property (fn[1] && !user_irq_busy_pin_oe);
endmodule // pin_ctrl_asserts
bind multi_function_pin_control pin_ctrl_asserts chk_u (.*);

// *** verif/tb.sv ***
/* self-checking bench for the pin control block.
   assumes the board model pulls released pins high. */
`timescale 1ns/1ps
`include "pin_ctrl_defs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
  reg clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, strap = 0, cca = 0, req = 0;
  reg [5:0] adr = 0;
  reg [31:0] dat = 0, q;
  reg [3:0] ext_en = 0, ext_val = 0;
  wire [31:0] rdat;
  wire ack, irq;
  wire [3:0] oe, o, lvl;
  int num_errors = 0, total_checks = 0, cycles = 0;
  multi_function_pin_control dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq(irq), .isa_strap(strap), .internal_cca(cca), .isa_irq_request(req),
    .user_irq_busy_pin_i(lvl[0]), .user_irq_busy_pin_o(o[0]), .user_irq_busy_pin_oe(oe[0]),
    .traffic_indicator_pin_i(lvl[1]), .traffic_indicator_pin_o(o[1]),
    .traffic_indicator_pin_oe(oe[1]), .link_indicator_pin_i(lvl[2]),
    .link_indicator_pin_o(o[2]), .link_indicator_pin_oe(oe[2]),
    .serial_device_clock_pin_i(lvl[3]), .serial_device_clock_pin_o(o[3]),
    .serial_device_clock_pin_oe(oe[3]));
  pin_board board_u (.oe(oe), .o(o), .ext_en(ext_en), .ext_val(ext_val), .level(lvl));
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task io(input [5:0] a, input wr, input [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task t_ind;
    for (int k = 0; k < 4; k++) begin
      io(`OFS_DRIVE, 1, {30'h0, k[1], k[1]});
      io(`OFS_INDICATOR, 1, {30'h0, k[0], k[0]});
      w(2);
      `CHK(oe[2:1], k[1] ? 2'h3 : {k[0], k[0]})
      `CHK(o[2:1], (k[1] && !k[0]) ? 2'h3 : 2'h0)
    end
    io(`OFS_ENABLE, 1, 32'h8);
    ext_en <= 4'h6;
    ext_val <= 4'h2;
    w(4);
    `CHK(oe[2:1], 2'h0)
    io(`OFS_INDICATOR, 0, 0);
    `CHK(q, 32'h1)
    ext_en <= 4'h0;
    $display("indicator test done");
  endtask
  task t_serial;
    int n;
    io(`OFS_SERIAL, 1, 32'h1);
    w(2);
    `CHK(o[3], 1'b1)
    io(`OFS_SERIAL, 0, 0);
    `CHK(q[0], 1'b1)
    for (int d = 0; d < 2; d++) begin
      n = 0;
      io(`OFS_SERIAL, 1, 32'h2 | d);
      w(1);
      repeat (6) begin
        @(posedge clk);
        n += (o[3] !== d[0]);
      end
      `CHK(n, 1)
    end
    io(`OFS_ENABLE, 1, 32'h0);
    ext_en <= 4'h8;
    w(4);
    `CHK(oe[3], 1'b0)
    io(`OFS_SERIAL, 0, 0);
    `CHK(q[0], 1'b0)
    ext_en <= 4'h0;
    $display("serial test done");
  endtask
  task t_user;
    io(`OFS_ENABLE, 1, 32'h1);
    io(`OFS_USER_DATA, 1, 32'h1);
    w(2);
    `CHK(oe[0] & o[0], 1'b1)
    io(`OFS_USER_DATA, 0, 0);
    `CHK(q, 32'h1)
    strap <= 1'b1;
    req <= 1'b1;
    io(`OFS_IRQ_SELECT, 1, 32'h4);
    io(`OFS_IRQ_TYPE, 1, 32'h2);
    w(2);
    `CHK({oe[0], o[0]}, 2'h3)
    io(`OFS_IRQ_TYPE, 1, 32'h1);
    w(2);
    `CHK(oe[0], 1'b0)
    req <= 1'b0;
    w(2);
    `CHK({oe[0], o[0]}, 2'h2)
    io(`OFS_FUNCTION, 1, 32'h2);
    w(2);
    `CHK(oe[0], 1'b0)
    $display("user pin test done");
  endtask
  task t_busy;
    ext_en <= 4'h1;
    w(4);
    io(`OFS_INT_ENABLE, 1, 32'h3);
    io(`OFS_INT_CLEAR, 1, 32'h3);
    io(`OFS_INT_STATUS, 0, 0);
    `CHK(q, 32'h0)
    ext_val <= 4'h1;
    w(5);
    io(`OFS_CHANNEL, 0, 0);
    `CHK(q, 32'h3)
    io(`OFS_INT_STATUS, 0, 0);
    `CHK(q, 32'h3)
    io(`OFS_ENABLE, 1, 32'h0);
    w(2);
    `CHK(irq, 1'b1)
    io(`OFS_INT_ENABLE, 1, 32'h0);
    w(2);
    `CHK(irq, 1'b0)
    cca <= 1'b1;
    ext_val <= 4'h0;
    w(4);
    io(`OFS_CHANNEL, 0, 0);
    `CHK(q, 32'h0)
    io(`OFS_FUNCTION, 1, 32'h0);
    w(2);
    io(`OFS_CHANNEL, 0, 0);
    `CHK(q, 32'h3)
    $display("busy test done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    w(2);
    `CHK({oe, o}, 8'h80)
    io(`OFS_ENABLE, 0, 0);
    `CHK(q, 32'hE)
    io(6'h30, 0, 0);
    `CHK(q, 32'h0)
    t_ind;
    t_serial;
    t_user;
    t_busy;
    test_done;
  end
endmodule // tb
